//--- src/scc_regs.svh
// Register offsets, field positions, reset values and timing figures of the calibration control bank
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_ADDR_BUFF_BIAS 7'h19
`define SCC_ADDR_LOOP_BW 7'h1a
`define SCC_ADDR_CAL_CTRL 7'h1b
`define SCC_RST_BUFF_BIAS 8'h45
`define SCC_RST_LOOP_BW 8'h86
`define SCC_RST_CAL_CTRL 8'h0d
`define SCC_BIT_CAL_TRIGGER 7
`define SCC_BIT_CAL_DUAL 6
`define SCC_MASK_BUFF_BIAS 8'hc7
`define SCC_DIV_NEW0 9'h008
`define SCC_DIV_NEW1 9'h010
`define SCC_DIV_NEW2 9'h028
`define SCC_DIV_NEW3 9'h050
`define SCC_DIV_OLD0 9'h050
`define SCC_DIV_OLD1 9'h080
`define SCC_DIV_OLD2 9'h0a0
`define SCC_DIV_OLD3 9'h100
`define SCC_OLD_TIME0 90000
`define SCC_OLD_TIME1 110000
`define SCC_OLD_TIME2 130000
`define SCC_OLD_TIME3 200000
`define SCC_NEW_STEPS 1024
`endif

//--- src/scc_pkg.sv
// Types shared by the synthesizer calibration control bank
package scc_pkg;
  typedef struct packed {
    logic trigger;
    logic dual;
    logic [1:0] wait_code;
    logic routine_new;
    logic [2:0] dac_start_value;
  } scc_cal_ctrl_t;

  typedef struct packed {
    logic [1:0] prescaler_bias;
    logic [2:0] rsvd;
    logic [2:0] lo_buffer_bias;
  } scc_buff_bias_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } scc_cfg_req_t;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_RUN = 2'b01,
    SCC_STORE = 2'b11
  } scc_state_t;
endpackage

//--- src/scc_top.sv
// Calibration control bank: configuration registers and calibration run sequencing
//
// Summary of operation
// - A 0-to-1 change of the calibration trigger bit starts a run, and with the bit at 0 no run is active.
// - With the store-both bit set, the result of a run is written into frequency sets A and B.
// - With the store-both bit clear, the result goes only to the set chosen by the frequency-set select input.
// - The new routine divides the calibration clock by 8, 16, 40 or 80 for wait codes 0 to 3.
// - The legacy routine divides the calibration clock by 80, 128, 160 or 256 for wait codes 0 to 3.
// - A legacy run lasts about 90000, 110000, 130000 or 200000 reference periods for wait codes 0 to 3.
// - The routine select bit picks legacy at 0 and new at 1, resets to 1, and 1 is recommended.
// - The three-bit start field sets the DAC start value to the code plus one, resets to 5, and 4 is recommended.
// - An eight-bit loop bandwidth scaling value is held for charge pump calibration and resets to 134.
// - The two-bit prescaler bias selects nominal, 2/3, 1/2 or 2/5 current, resets to 1, and 0 is recommended.
// - The three-bit LO buffer bias runs from minimum at 0 to maximum at 7 and resets to 5.
`timescale 1ns/1ps
`include "scc_regs.svh"

module scc_top
#(
  parameter int OLD_TIME0 = `SCC_OLD_TIME0,
  parameter int OLD_TIME1 = `SCC_OLD_TIME1,
  parameter int OLD_TIME2 = `SCC_OLD_TIME2,
  parameter int OLD_TIME3 = `SCC_OLD_TIME3,
  parameter int NEW_STEPS = `SCC_NEW_STEPS
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Configuration port
  input wire scc_pkg::scc_cfg_req_t cfg_req_i,
  output logic [7:0] cfg_rdata_o,
  // Reference timing and frequency-set select
  input wire logic ref_tick_i,
  input wire logic freq_set_sel_i,
  // Analog settings
  output scc_pkg::scc_buff_bias_t buff_bias_o,
  output logic [7:0] loop_bandwidth_scale_o,
  // Calibration run
  output logic cal_busy_o,
  output logic cal_tick_o,
  output logic [8:0] cal_div_o,
  output logic [3:0] dac_start_o,
  output logic store_a_o,
  output logic store_b_o
);
  import scc_pkg::*;

  if (NEW_STEPS < 1 || NEW_STEPS > 262143 || OLD_TIME0 < 1 || OLD_TIME1 < 1 || OLD_TIME2 < 1 || OLD_TIME3 < 1 ||
      OLD_TIME0 > 262143 || OLD_TIME1 > 262143 || OLD_TIME2 > 262143 || OLD_TIME3 > 262143)
  begin : g_bad_param
    $error("scc_top: run length parameters out of range");
  end

  scc_cal_ctrl_t cal_ctrl;
  scc_cal_ctrl_t next_cal_ctrl;
  scc_buff_bias_t next_buff_bias;
  logic [7:0] next_loop_bw;
  logic [7:0] next_rdata;
  scc_state_t state;
  scc_state_t next_state;
  logic [8:0] div_cnt;
  logic [8:0] next_div_cnt;
  logic [17:0] ref_cnt;
  logic [17:0] next_ref_cnt;
  logic [17:0] step_cnt;
  logic [17:0] next_step_cnt;
  logic next_busy;
  logic next_tick;
  logic [8:0] next_div;
  logic [3:0] next_dac;
  logic next_store_a;
  logic next_store_b;
  logic cal_wr;
  logic [8:0] div_sel;
  logic [17:0] old_end;
  logic run_done;

  assign cal_wr = cfg_req_i.wr && (cfg_req_i.addr == `SCC_ADDR_CAL_CTRL);

  // Divider chosen by routine and wait code
  always_comb
  begin
    div_sel = `SCC_DIV_OLD0;
    old_end = 18'(OLD_TIME0 - 1);
    if (cal_ctrl.routine_new)
    begin
      case (cal_ctrl.wait_code)
        2'h0: div_sel = `SCC_DIV_NEW0;
        2'h1: div_sel = `SCC_DIV_NEW1;
        2'h2: div_sel = `SCC_DIV_NEW2;
        default: div_sel = `SCC_DIV_NEW3;
      endcase
    end
    else
    begin
      case (cal_ctrl.wait_code)
        2'h0: div_sel = `SCC_DIV_OLD0;
        2'h1: div_sel = `SCC_DIV_OLD1;
        2'h2: div_sel = `SCC_DIV_OLD2;
        default: div_sel = `SCC_DIV_OLD3;
      endcase
    end
    case (cal_ctrl.wait_code)
      2'h0: old_end = 18'(OLD_TIME0 - 1);
      2'h1: old_end = 18'(OLD_TIME1 - 1);
      2'h2: old_end = 18'(OLD_TIME2 - 1);
      default: old_end = 18'(OLD_TIME3 - 1);
    endcase
  end

  // Register bank
  always_comb
  begin
    next_cal_ctrl = cal_ctrl;
    next_buff_bias = buff_bias_o;
    next_loop_bw = loop_bandwidth_scale_o;
    next_rdata = 8'h00;
    if (cfg_req_i.wr)
    begin
      case (cfg_req_i.addr)
        `SCC_ADDR_BUFF_BIAS: next_buff_bias = cfg_req_i.wdata & `SCC_MASK_BUFF_BIAS;
        `SCC_ADDR_LOOP_BW: next_loop_bw = cfg_req_i.wdata;
        `SCC_ADDR_CAL_CTRL: next_cal_ctrl = cfg_req_i.wdata;
        default: next_rdata = 8'h00;
      endcase
    end
    if (cfg_req_i.rd)
    begin
      case (cfg_req_i.addr)
        `SCC_ADDR_BUFF_BIAS: next_rdata = buff_bias_o;
        `SCC_ADDR_LOOP_BW: next_rdata = loop_bandwidth_scale_o;
        `SCC_ADDR_CAL_CTRL: next_rdata = cal_ctrl;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cal_ctrl <= `SCC_RST_CAL_CTRL;
      buff_bias_o <= `SCC_RST_BUFF_BIAS;
      loop_bandwidth_scale_o <= `SCC_RST_LOOP_BW;
      cfg_rdata_o <= 8'h00;
    end
    else
    begin
      cal_ctrl <= next_cal_ctrl;
      buff_bias_o <= next_buff_bias;
      loop_bandwidth_scale_o <= next_loop_bw;
      cfg_rdata_o <= next_rdata;
    end
  end

  // Legacy runs end on total reference periods, new runs on a count of calibration steps
  assign run_done = cal_ctrl.routine_new ? (cal_tick_o && step_cnt == 18'(NEW_STEPS - 1))
                                         : (ref_tick_i && ref_cnt == old_end);

  // Calibration sequencer
  always_comb
  begin
    next_state = state;
    next_div_cnt = div_cnt;
    next_ref_cnt = ref_cnt;
    next_step_cnt = step_cnt;
    next_busy = cal_busy_o;
    next_tick = 1'b0;
    next_div = cal_div_o;
    next_dac = dac_start_o;
    next_store_a = 1'b0;
    next_store_b = 1'b0;
    case (state)
      SCC_IDLE:
      begin
        if (cal_wr && cfg_req_i.wdata[`SCC_BIT_CAL_TRIGGER] && !cal_ctrl.trigger)
        begin
          next_state = SCC_RUN;
          next_busy = 1'b1;
          next_div_cnt = 9'h000;
          next_ref_cnt = 18'h00000;
          next_step_cnt = 18'h00000;
          next_dac = {1'b0, cfg_req_i.wdata[2:0]} + 4'h1;
        end
      end
      SCC_RUN:
      begin
        next_div = div_sel;
        if (ref_tick_i)
        begin
          next_ref_cnt = ref_cnt + 18'h00001;
          if (div_cnt >= div_sel - 9'h001)
          begin
            next_div_cnt = 9'h000;
            next_tick = 1'b1;
          end
          else
          begin
            next_div_cnt = div_cnt + 9'h001;
          end
        end
        if (cal_tick_o)
        begin
          next_step_cnt = step_cnt + 18'h00001;
        end
        if (cal_wr && !cfg_req_i.wdata[`SCC_BIT_CAL_TRIGGER])
        begin
          next_state = SCC_IDLE;
          next_busy = 1'b0;
        end
        else if (run_done)
        begin
          next_state = SCC_STORE;
        end
      end
      SCC_STORE:
      begin
        // One-cycle write strobe towards the frequency register sets
        next_store_a = cal_ctrl.dual || !freq_set_sel_i;
        next_store_b = cal_ctrl.dual || freq_set_sel_i;
        next_busy = 1'b0;
        next_state = SCC_IDLE;
      end
      default:
      begin
        next_state = SCC_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= SCC_IDLE;
      div_cnt <= 9'h000;
      ref_cnt <= 18'h00000;
      step_cnt <= 18'h00000;
      cal_busy_o <= 1'b0;
      cal_tick_o <= 1'b0;
      cal_div_o <= `SCC_DIV_NEW0;
      dac_start_o <= 4'h6;
      store_a_o <= 1'b0;
      store_b_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      ref_cnt <= next_ref_cnt;
      step_cnt <= next_step_cnt;
      cal_busy_o <= next_busy;
      cal_tick_o <= next_tick;
      cal_div_o <= next_div;
      dac_start_o <= next_dac;
      store_a_o <= next_store_a;
      store_b_o <= next_store_b;
    end
  end

  // Helper: reference periods since the last step or the run start, held at zero while idle
  logic [8:0] gap_cnt;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      gap_cnt <= 9'h000;
    else if (cal_tick_o || !cal_busy_o)
      gap_cnt <= {8'h00, ref_tick_i && cal_busy_o};
    else if (ref_tick_i)
      gap_cnt <= gap_cnt + 9'h001;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_start;
    (state == SCC_IDLE && cal_wr && cfg_req_i.wdata[7] && !cal_ctrl.trigger) |=> cal_busy_o && cal_ctrl.trigger;
  endproperty
  a_start: assert property (p_start) else $error("run did not start on trigger rise");

  property p_abort;
    (state == SCC_RUN && cal_wr && !cfg_req_i.wdata[7]) |=> !cal_busy_o ##1 !store_a_o && !store_b_o;
  endproperty
  a_abort: assert property (p_abort) else $error("run continued with trigger at 0");

  property p_dual;
    (state == SCC_STORE && cal_ctrl.dual) |=> store_a_o && store_b_o;
  endproperty
  a_dual: assert property (p_dual) else $error("dual store missed a set");

  property p_single;
    (state == SCC_STORE && !cal_ctrl.dual) |=> (store_b_o == $past(freq_set_sel_i)) && (store_a_o != store_b_o);
  endproperty
  a_single: assert property (p_single) else $error("single store hit wrong set");
  property p_div_new;
    (state == SCC_RUN && cal_ctrl.routine_new && cal_tick_o)
      |-> gap_cnt == (cal_ctrl.wait_code == 2'h0 ? 9'd8 : cal_ctrl.wait_code == 2'h1 ? 9'd16 :
                      cal_ctrl.wait_code == 2'h2 ? 9'd40 : 9'd80) && cal_div_o == gap_cnt;
  endproperty
  a_div_new: assert property (p_div_new) else $error("new routine divider wrong");
  property p_div_old;
    (state == SCC_RUN && !cal_ctrl.routine_new && cal_tick_o)
      |-> gap_cnt == (cal_ctrl.wait_code == 2'h0 ? 9'd80 : cal_ctrl.wait_code == 2'h1 ? 9'd128 :
                      cal_ctrl.wait_code == 2'h2 ? 9'd160 : 9'd256) && cal_div_o == gap_cnt;
  endproperty
  a_div_old: assert property (p_div_old) else $error("legacy step gap wrong");
  property p_old_time;
    (state == SCC_RUN && !cal_ctrl.routine_new && ref_tick_i && ref_cnt == old_end && !cal_wr) |=> state == SCC_STORE;
  endproperty
  a_old_time: assert property (p_old_time) else $error("legacy run length wrong");
  property p_dac;
    (state == SCC_IDLE && cal_wr && cfg_req_i.wdata[7] && !cal_ctrl.trigger)
      |=> dac_start_o == {1'b0, $past(cfg_req_i.wdata[2:0])} + 4'h1;
  endproperty
  a_dac: assert property (p_dac) else $error("dac start not code plus one");

  property p_bw_read;
    (cfg_req_i.rd && cfg_req_i.addr == `SCC_ADDR_LOOP_BW && !cfg_req_i.wr)
      |=> cfg_rdata_o == $past(loop_bandwidth_scale_o);
  endproperty
  a_bw_read: assert property (p_bw_read) else $error("loop bandwidth readback wrong");
  property p_bias_rsvd;
    (cfg_req_i.rd && cfg_req_i.addr == `SCC_ADDR_BUFF_BIAS) |=> cfg_rdata_o[5:3] == 3'h0;
  endproperty
  a_bias_rsvd: assert property (p_bias_rsvd) else $error("reserved bias bits not zero");

  property p_end;
    (store_a_o || store_b_o) |-> $past(state) == SCC_STORE && !cal_busy_o;
  endproperty
  a_end: assert property (p_end) else $error("store outside run end");

  c_run: cover property (state == SCC_RUN ##1 state == SCC_STORE);
  c_dual: cover property (store_a_o && store_b_o);
  c_abort: cover property (state == SCC_RUN && cal_wr && !cfg_req_i.wdata[7]);
endmodule

//--- bench/scc_host.sv
// Host model driving the configuration port of the calibration bank
`timescale 1ns/1ps
module scc_host
(
  // Clock
  input wire logic clk_sys_i,
  // Configuration port
  output scc_pkg::scc_cfg_req_t cfg_req_o,
  input wire logic [7:0] cfg_rdata_i
);
  import scc_pkg::*;
  initial cfg_req_o = '0;
  // Idle address and data are inverted so a stale value never looks like a request
  task automatic put(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    cfg_req_o = '{w, r, a, d};
    @(posedge clk_sys_i);
    #1;
    cfg_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    put(1'b0, 1'b1, a, 8'h00);
    d = cfg_rdata_i;
  endtask
  // Slowest wait code trades run time for the best loop bandwidth accuracy
  task automatic cal_best(input logic dual);
    wr(7'h1b, {1'b1, dual, 2'h3, 1'b1, 3'h4});
  endtask
endmodule

//--- bench/test_synth_calibration_control.sv
// Self-checking testbench of the calibration control bank
`timescale 1ns/1ps
module test_synth_calibration_control;
  import scc_pkg::*;
  localparam int NSTEP = 4;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ref_tick_i = 1'b1;
  logic freq_set_sel_i = 1'b0;
  scc_cfg_req_t cfg_req;
  logic [7:0] rdata;
  scc_buff_bias_t bias;
  logic [7:0] loop_bw;
  logic busy;
  logic tick;
  logic sta;
  logic stb;
  logic [8:0] div;
  logic [3:0] dac;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h7d42;

  // Legacy run lengths exceed their dividers so legacy runs make calibration steps too
  scc_top #(.OLD_TIME0(170), .OLD_TIME1(260), .OLD_TIME2(330), .OLD_TIME3(520), .NEW_STEPS(NSTEP)) u_dut
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cfg_req_i(cfg_req),
    .cfg_rdata_o(rdata),
    .ref_tick_i(ref_tick_i),
    .freq_set_sel_i(freq_set_sel_i),
    .buff_bias_o(bias),
    .loop_bandwidth_scale_o(loop_bw),
    .cal_busy_o(busy),
    .cal_tick_o(tick),
    .cal_div_o(div),
    .dac_start_o(dac),
    .store_a_o(sta),
    .store_b_o(stb)
  );

  scc_host u_host
  (
    .clk_sys_i(clk_sys_i),
    .cfg_req_o(cfg_req),
    .cfg_rdata_i(rdata)
  );

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [8:0] div_exp(input logic sel, input logic [1:0] w);
    logic [8:0] t [8] = '{9'h050, 9'h080, 9'h0a0, 9'h100, 9'h008, 9'h010, 9'h028, 9'h050};
    return t[{sel, w}];
  endfunction

  function automatic int len_exp(input logic sel, input logic [1:0] w);
    int old [4] = '{170, 260, 330, 520};
    return sel ? NSTEP * div_exp(sel, w) : old[w];
  endfunction

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One run: start, watch to completion, then a repeated 1 must not restart it
  task automatic run(input logic sel, input logic [1:0] w, input logic dual, input logic gate);
    logic [2:0] st;
    logic fs;
    logic got;
    int n;
    int ticks;
    int e;
    int refs;
    st = 3'($random(seed));
    fs = 1'($random(seed));
    got = 1'b0;
    n = 0;
    ticks = 0;
    // Reference ticks sampled at the first two edges of the run are still the idle 1
    refs = 2;
    e = len_exp(sel, w);
    freq_set_sel_i = fs;
    u_host.wr(7'h1b, {1'b1, dual, w, sel, st});
    @(posedge clk_sys_i);
    #1;
    chk("busy", 16'h1, {15'h0, busy});
    chk("dac_start", {13'h0, st} + 16'h1, {12'h0, dac});
    while (busy === 1'b1 && n < 5000)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (tick === 1'b1)
        ticks++;
      if (n == 3)
        chk("cal_div", {7'h0, div_exp(sel, w)}, {7'h0, div});
      if (sta === 1'b1 || stb === 1'b1)
      begin
        got = 1'b1;
        chk("store_a", {15'h0, dual | ~fs}, {15'h0, sta});
        chk("store_b", {15'h0, dual | fs}, {15'h0, stb});
      end
      // Gated runs show that steps follow reference periods, not system clock cycles
      ref_tick_i = (gate && busy === 1'b1) ? 1'($random(seed)) : 1'b1;
      if (ref_tick_i === 1'b1)
        refs++;
    end
    chk("stored", 16'h1, {15'h0, got});
    chk("run_refs_ok", 16'h1, {15'h0, refs >= e + 1 && refs <= e + 3});
    chk("cal_ticks", 16'(e / div_exp(sel, w)), 16'(ticks));
    u_host.wr(7'h1b, {1'b1, dual, w, sel, st});
    @(posedge clk_sys_i);
    #1;
    chk("no_restart", 16'h0, {15'h0, busy});
    u_host.wr(7'h1b, {1'b0, dual, w, sel, st});
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] r;
    int s;
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    chk("bias_o_rst", 16'h45, {8'h0, bias});
    chk("loop_bw_o_rst", 16'h86, {8'h0, loop_bw});
    chk("dac_rst", 16'h6, {12'h0, dac});
    u_host.rd(7'h1b, r);
    chk("cal_ctrl_rst", 16'h0d, {8'h0, r});
    u_host.rd(7'h1a, r);
    chk("loop_bw_rst", 16'h86, {8'h0, r});
    u_host.rd(7'h19, r);
    chk("bias_rst", 16'h45, {8'h0, r});
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      u_host.wr(7'h19, d);
      u_host.rd(7'h19, r);
      chk("bias", {8'h0, d & 8'hc7}, {8'h0, r});
      chk("bias_o", {8'h0, d & 8'hc7}, {8'h0, bias});
      u_host.wr(7'h1a, d);
      u_host.rd(7'h1a, r);
      chk("loop_bw", {8'h0, d}, {8'h0, r});
      chk("loop_bw_o", {8'h0, d}, {8'h0, loop_bw});
      u_host.rd(7'h20 + 7'(i), r);
      chk("unmapped", 16'h0, {8'h0, r});
    end
    $display("Test registers done");
    for (int k = 0; k < 16; k++)
      run(k[2], k[1:0], 1'($random(seed)), k[3]);
    $display("Test runs done");
    s = 0;
    u_host.cal_best(1'b1);
    repeat (20) @(posedge clk_sys_i);
    #1;
    u_host.wr(7'h1b, 8'h3c);
    chk("abort_busy", 16'h0, {15'h0, busy});
    repeat (400)
    begin
      @(posedge clk_sys_i);
      #1;
      s += sta + stb;
    end
    chk("abort_stores", 16'h0, 16'(s));
    $display("Test abort done");
    report_and_stop();
  end
endmodule
